//--- hdl/lcam_top.sv
// Line-cycle accumulation mode register with its window timing logic.
// Assumes AXI4-Lite master, same-clock zero-crossing pulses and read strobe.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Bit 0 selects active-energy line-cycle mode
// - Bit 1 selects reactive-energy line-cycle mode
// - Bit 2 selects apparent-energy line-cycle mode
// - Bits 3-5 enable phases A-C, reset one
// - All enabled phases advance one shared count
// - Bit 6 set: accumulator read clears it
// - Bit 7 reserved, resets zero, no effect
module lcam_top
	import lcam_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [2:0] ZC_PHASE,
	input wire logic [CYC_W-1:0] LINE_CYCLES,
	input wire logic ACCUM_READ,
	output logic ACCUM_CLEAR,
	output logic ACTIVE_LINE_MODE,
	output logic REACTIVE_LINE_MODE,
	output logic APPARENT_LINE_MODE,
	output logic WINDOW_DONE,
	output logic [2:0] ACCUM_LATCH
);
	lcam_mode_t mode;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_ok, w_ok, wr_do, wr_hit, wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [CNT_W-1:0] zc_count;
	logic [CNT_W-1:0] next_zc_count;
	logic [2:0] zc_hit;
	logic [1:0] zc_inc;
	logic window_close;

	// Address and data held until both are in; either may come first
	assign aw_ok = !S_AXI_AWREADY || S_AXI_AWVALID;
	assign w_ok = !S_AXI_WREADY || S_AXI_WVALID;
	assign wr_do = aw_ok && w_ok && !S_AXI_BVALID;
	assign wr_addr = S_AXI_AWREADY ? S_AXI_AWADDR : aw_addr;
	assign wr_data = S_AXI_WREADY ? S_AXI_WDATA : w_data;
	assign wr_strb = S_AXI_WREADY ? S_AXI_WSTRB : w_strb;
	assign wr_hit = wr_addr[ADDR_W-1:2] == MODE_ADDR[ADDR_W-1:2];
	assign wr_en = wr_do && wr_hit && wr_strb[0];

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			S_AXI_AWREADY <= 1'b1;
			aw_addr <= '0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			S_AXI_AWREADY <= 1'b0;
			aw_addr <= S_AXI_AWADDR;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			S_AXI_WREADY <= 1'b1;
			w_data <= '0;
			w_strb <= '0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			S_AXI_WREADY <= 1'b0;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (wr_do) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// All eight bits stored and read back, reserved one included
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mode <= lcam_mode_t'(MODE_RESET);
		end else if (wr_en) begin
			mode <= lcam_mode_t'(wr_data[7:0]);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			if (S_AXI_ARADDR[ADDR_W-1:2] == MODE_ADDR[ADDR_W-1:2]) begin
				S_AXI_RDATA <= {24'h000000, mode};
				S_AXI_RRESP <= RESP_OKAY;
			end else begin
				S_AXI_RDATA <= '0;
				S_AXI_RRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// Mode outputs; the reserved bit drives nothing
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ACTIVE_LINE_MODE <= MODE_RESET[BIT_ACTIVE];
			REACTIVE_LINE_MODE <= MODE_RESET[BIT_REACTIVE];
			APPARENT_LINE_MODE <= MODE_RESET[BIT_APPARENT];
		end else begin
			ACTIVE_LINE_MODE <= mode.active_energy_line_mode;
			REACTIVE_LINE_MODE <= mode.reactive_energy_line_mode;
			APPARENT_LINE_MODE <= mode.apparent_energy_line_mode;
		end
	end

	// Clear-on-read; with it off the accumulators keep their value
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ACCUM_CLEAR <= 1'b0;
		end else begin
			ACCUM_CLEAR <= ACCUM_READ && mode.clear_on_read_enable;
		end
	end

	// Several phases share one count, so windows shorten
	assign zc_hit = ZC_PHASE & mode.zero_cross_phase_select;
	assign zc_inc = {1'b0, zc_hit[0]} + {1'b0, zc_hit[1]} + {1'b0, zc_hit[2]};
	assign next_zc_count = zc_count + {{(CNT_W-2){1'b0}}, zc_inc};
	// A zero target never closes a window rather than closing every cycle
	assign window_close = (LINE_CYCLES != '0)
		&& (next_zc_count >= {1'b0, LINE_CYCLES});

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			zc_count <= '0;
		end else if (window_close) begin
			zc_count <= '0;
		end else begin
			zc_count <= next_zc_count;
		end
	end

	// Regular mode latches every cycle, line mode once per window
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			WINDOW_DONE <= 1'b0;
			ACCUM_LATCH <= 3'h7;
		end else begin
			WINDOW_DONE <= window_close;
			ACCUM_LATCH[0] <= !mode.active_energy_line_mode || window_close;
			ACCUM_LATCH[1] <= !mode.reactive_energy_line_mode || window_close;
			ACCUM_LATCH[2] <= !mode.apparent_energy_line_mode || window_close;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	sequence s_write_mode;
		wr_en;
	endsequence

	sequence s_window_close;
		window_close;
	endsequence

	property p_active_write;
		s_write_mode |=> ##1 ACTIVE_LINE_MODE == $past(wr_data[0], 2);
	endproperty
	a_active_write: assert property (p_active_write)
		else $error("active mode output does not follow write");

	property p_reactive_write;
		s_write_mode |=> ##1 REACTIVE_LINE_MODE == $past(wr_data[1], 2);
	endproperty
	a_reactive_write: assert property (p_reactive_write)
		else $error("reactive mode output does not follow write");

	property p_apparent_write;
		s_write_mode |=> ##1 APPARENT_LINE_MODE == $past(wr_data[2], 2);
	endproperty
	a_apparent_write: assert property (p_apparent_write)
		else $error("apparent mode output does not follow write");

	property p_phase_gate;
		(ZC_PHASE != 3'h0 && !window_close
			&& (ZC_PHASE & mode.zero_cross_phase_select) == 3'h0)
			|=> zc_count == $past(zc_count);
	endproperty
	a_phase_gate: assert property (p_phase_gate)
		else $error("crossing of a disabled phase was counted");

	property p_shared_count;
		(!window_close && zc_hit == 3'h7) |=> zc_count == $past(zc_count) + 3;
	endproperty
	a_shared_count: assert property (p_shared_count)
		else $error("three phases did not add three");

	property p_clear_on_read;
		(ACCUM_READ && mode.clear_on_read_enable) |=> ACCUM_CLEAR;
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("read did not clear accumulator");

	property p_no_clear;
		!mode.clear_on_read_enable |=> !ACCUM_CLEAR;
	endproperty
	a_no_clear: assert property (p_no_clear)
		else $error("clear issued with clear-on-read off");

	property p_line_latch_hold;
		(mode.active_energy_line_mode && !window_close) |=> !ACCUM_LATCH[0];
	endproperty
	a_line_latch_hold: assert property (p_line_latch_hold)
		else $error("latch in line mode outside window");

	// Reserved bit alone changing must leave every mode output as it was
	property p_reserved_inert;
		(wr_en && wr_data[6:0] == 7'(mode))
			|=> ##1 $stable({ACTIVE_LINE_MODE, REACTIVE_LINE_MODE,
			APPARENT_LINE_MODE});
	endproperty
	a_reserved_inert: assert property (p_reserved_inert)
		else $error("reserved bit changed a mode output");

	property p_window_once;
		WINDOW_DONE |=> zc_count <= 3;
	endproperty
	a_window_once: assert property (p_window_once)
		else $error("count not restarted after window");

	property p_readback;
		(S_AXI_ARVALID && S_AXI_ARREADY && !wr_en
			&& S_AXI_ARADDR[ADDR_W-1:2] == MODE_ADDR[ADDR_W-1:2])
			|=> S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(mode);
	endproperty
	a_readback: assert property (p_readback)
		else $error("read data differs from register");

	property p_reset_mode;
		$past(SRST) |-> mode == MODE_RESET;
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("mode register not at reset value");

	// A clear without a read would wipe energy nobody has seen
	property p_clear_needs_read;
		ACCUM_CLEAR |-> $past(ACCUM_READ);
	endproperty
	a_clear_needs_read: assert property (p_clear_needs_read)
		else $error("clear issued without an accumulator read");

	property p_regular_latch;
		!mode.active_energy_line_mode |=> ACCUM_LATCH[0];
	endproperty
	a_regular_latch: assert property (p_regular_latch)
		else $error("regular mode did not latch every cycle");

	property p_reactive_hold;
		(mode.reactive_energy_line_mode && !window_close) |=> !ACCUM_LATCH[1];
	endproperty
	a_reactive_hold: assert property (p_reactive_hold)
		else $error("reactive latch in line mode outside window");

	property p_window_latch;
		s_window_close |=> WINDOW_DONE && ACCUM_LATCH == 3'h7;
	endproperty
	a_window_latch: assert property (p_window_latch)
		else $error("closed window did not pulse done and latch");

	property p_write_answer;
		wr_do |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write not answered the next cycle");
endmodule

`default_nettype wire

//--- hdl/lcam_pkg.sv
// Constants and types for the line-cycle accumulation mode register.
// Assumes a 32-bit AXI4-Lite slave with 20-bit byte addresses.
package lcam_pkg;
	localparam int ADDR_W = 20;
	localparam logic [15:0] MODE_INDEX = 16'hE702;
	localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_INDEX, 2'h0};
	localparam int BIT_ACTIVE = 0;
	localparam int BIT_REACTIVE = 1;
	localparam int BIT_APPARENT = 2;
	localparam int BIT_ZX_LO = 3;
	localparam int BIT_CLEAR = 6;
	localparam int BIT_RSVD = 7;
	localparam logic [7:0] MODE_RESET = 8'h78;
	localparam int CYC_W = 16;
	localparam int CNT_W = 17;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic reserved;
		logic clear_on_read_enable;
		logic [2:0] zero_cross_phase_select;
		logic apparent_energy_line_mode;
		logic reactive_energy_line_mode;
		logic active_energy_line_mode;
	} lcam_mode_t;
endpackage

//--- tb/lcam_bench.sv
// Self-checking bench for the line-cycle mode register block.
// Assumes lcam_pkg and lcam_top compiled first; bench drives every port.
`timescale 1ns/100ps
`default_nettype none
module lcam_bench
	import lcam_pkg::*;
;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, acc_rd = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] zc = 3'h0;
	logic [CYC_W-1:0] lcyc = 16'h0;
	wire logic awready, wready, bvalid, arready, rvalid, acc_clr;
	wire logic act, rea, app, win;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] latch;
	int error_cnt = 0, check_count = 0, cyc = 0, win_cnt = 0;
	logic [2:0] win_latch = 3'h0;
	logic [1:0] resp;
	logic [31:0] rd;

	lcam_top DUT (.CLK_SYS(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .ZC_PHASE(zc), .LINE_CYCLES(lcyc),
		.ACCUM_READ(acc_rd), .ACCUM_CLEAR(acc_clr),
		.ACTIVE_LINE_MODE(act), .REACTIVE_LINE_MODE(rea),
		.APPARENT_LINE_MODE(app), .WINDOW_DONE(win), .ACCUM_LATCH(latch));

	always #10 clk = ~clk;

	// Window pulses counted here so a pulse is never missed between checks
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (win === 1'h1) begin
			win_cnt <= win_cnt + 1;
			win_latch <= latch;
		end
		if (cyc == 2000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
		#1;
	endtask

	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
		#1;
	endtask

	// One accumulator read strobe; clear shows the cycle after
	task automatic acc_read();
		@(posedge clk);
		acc_rd <= 1'h1;
		@(posedge clk);
		acc_rd <= 1'h0;
		#1;
	endtask

	task automatic zpulse(input logic [CYC_W-1:0] n, input logic [2:0] z);
		@(posedge clk);
		lcyc <= n;
		zc <= z;
		@(posedge clk);
		zc <= 3'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		rdr(MODE_ADDR);
		chk("reset value", 32'h78, rd);
		chk("line modes", 32'h0, 32'({app, rea, act}));
		chk("latch", 32'h7, 32'(latch));
		acc_read();
		chk("clear", 32'h1, 32'(acc_clr));
		wr(MODE_ADDR, 32'hFFFFFF87);
		chk("bresp", 32'(RESP_OKAY), 32'(resp));
		chk("line modes", 32'h7, 32'({app, rea, act}));
		rdr(MODE_ADDR);
		chk("readback", 32'h87, rd);
		acc_read();
		chk("clear", 32'h0, 32'(acc_clr));
		zpulse(16'h1, 3'h7);
		chk("windows", 32'h0, 32'(win_cnt));
		wr(MODE_ADDR, 32'h0F);
		zpulse(16'h2, 3'h7);
		chk("windows", 32'h0, 32'(win_cnt));
		chk("latch", 32'h0, 32'(latch));
		zpulse(16'h2, 3'h7);
		chk("windows", 32'h1, 32'(win_cnt));
		chk("window latch", 32'h7, 32'(win_latch));
		// Shared count: three phases in one edge close a three-crossing window
		wr(MODE_ADDR, 32'h39);
		zpulse(16'h3, 3'h7);
		chk("windows", 32'h2, 32'(win_cnt));
		chk("window latch", 32'h7, 32'(win_latch));
		chk("latch", 32'h6, 32'(latch));
		// Only the reserved bit differs, so nothing downstream may move
		wr(MODE_ADDR, 32'hB9);
		chk("line modes", 32'h1, 32'({app, rea, act}));
		chk("latch", 32'h6, 32'(latch));
		// Seven crossings: two triple edges leave it open, the third closes
		zpulse(16'h7, 3'h7);
		zpulse(16'h7, 3'h7);
		chk("windows", 32'h2, 32'(win_cnt));
		zpulse(16'h7, 3'h7);
		chk("windows", 32'h3, 32'(win_cnt));
		// Zero target never closes, however many crossings arrive
		zpulse(16'h0, 3'h7);
		zpulse(16'h0, 3'h7);
		chk("windows", 32'h3, 32'(win_cnt));
		wr(20'h00010, 32'hFF);
		chk("bresp", 32'(RESP_SLVERR), 32'(resp));
		// Low byte lane off: accepted, but the register keeps its value
		wr(MODE_ADDR, 32'h00, 4'hE);
		chk("bresp", 32'(RESP_OKAY), 32'(resp));
		rdr(MODE_ADDR);
		chk("readback", 32'hB9, rd);
		rdr(20'h00010);
		chk("rresp", 32'(RESP_SLVERR), 32'(resp));
		chk("unmapped data", 32'h0, rd);
		conclude();
	end
endmodule
`default_nettype wire
